// ### hdl/rst_clk_defs.svh
`ifndef RST_CLK_DEFS_SVH
`define RST_CLK_DEFS_SVH

// clock rate and timing figures
`define MAIN_CLK_MHZ        125
`define EXT_RST_MIN_PERIODS 12
`define EXT_RST_CYCLES      `EXT_RST_MIN_PERIODS
`define MALF_RST_MAX_PERIODS 24
`define MALF_RST_CYCLES     `MALF_RST_MAX_PERIODS
`define CLK_SYNC_CYCLES     4

// register offsets (byte addresses)
`define OFS_SYSTEM_CONTROL_TWO  8'h00
`define OFS_WATCHDOG_CONTROL_ONE 8'h04
`define OFS_STATUS             8'h08

// system_control_two field positions
`define BIT_FAST_OSC_ENABLE    7
`define BIT_SLOW_OSC_ENABLE    6
`define BIT_CLOCK_SOURCE_SELECT 5

// watchdog_control_one field positions
`define BIT_RAM_FETCH_TRAP_ENABLE 0
`define BIT_TRAP_RESET_SELECT     1

// reset values
`define RST_SYSTEM_CONTROL_TWO   8'h80
`define RST_WATCHDOG_CONTROL_ONE 8'h02

// reset vector addresses
`define RESET_VECTOR_LO 16'hFFFE
`define RESET_VECTOR_HI 16'hFFFF

`endif

// ### hdl/rst_clk_pkg.sv
package rst_clk_pkg;
  typedef enum logic [1:0] {
    AREA_ROM    = 2'b00,
    AREA_RAM    = 2'b01,
    AREA_BUFFER  = 2'b10,
    AREA_SPECIAL = 2'b11
  } fetch_area_t;

  typedef struct packed {
    logic        valid;
    fetch_area_t area;
  } fetch_info_t;

  typedef struct packed {
    logic ext_pin;
    logic addr_trap;
    logic watchdog;
    logic sys_clock;
  } reset_cause_t;

  typedef enum logic [1:0] {
    CLK_FAST      = 2'b00,
    CLK_SLOW      = 2'b01,
    CLK_SYNC_FAST = 2'b10
  } clk_state_t;
endpackage : rst_clk_pkg

// ### hdl/reset_stretch.sv
`timescale 1ns/1ps
`include "rst_clk_defs.svh"

// holds reset for a fixed count after any malfunction request
module reset_stretch (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // request and stretched output
  input  wire logic malf_req,
  output logic      malf_active
);
  logic [4:0] cnt_reg;
  logic [4:0] cnt_next;

  always_comb begin
    cnt_next = cnt_reg;
    if (malf_req) begin
      cnt_next = 5'(`MALF_RST_CYCLES - 1);
    end else if (cnt_reg != 5'h00) begin
      cnt_next = cnt_reg - 5'h01;
    end
  end

  // counter has no power-up clear; the block reset arms a full-length stretch,
  // which is the worst case and gives simulation a known starting count
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_reg <= 5'(`MALF_RST_CYCLES - 1);
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign malf_active = malf_req || (cnt_reg != 5'h00);
endmodule : reset_stretch

// ### hdl/reset_and_clock_switch_ctrl.sv
// Implementation choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`include "rst_clk_defs.svh"

module reset_and_clock_switch_ctrl
  import rst_clk_pkg::*;
(
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  // reset pin, active low, asynchronous
  input  wire logic                     reset_pin_n,
  // watchdog and fetch monitor
  input  wire logic                     watchdog_req,
  input  rst_clk_pkg::fetch_info_t      fetch,
  // register port
  input  wire logic [7:0]               addr,
  input  wire logic [7:0]               wdata,
  input  wire logic                     wr,
  input  wire logic                     rd,
  output logic [7:0]                    rdata,
  // reset and interrupt clears
  output logic                          sys_reset,
  output logic                          vector_fetch,
  output logic [15:0]                   vector_addr,
  output logic                          trap_irq,
  output logic                          master_interrupt_enable,
  output logic [23:0]                   source_interrupt_enables,
  output logic [23:0]                   pending_request_latches,
  output logic [7:0]                    tg_prescaler,
  output logic                          watchdog_enable,
  // clock control
  output logic                          fast_osc_enable,
  output logic                          slow_osc_enable,
  output logic                          use_slow_clock
);
  import rst_clk_pkg::*;

  logic               pin_s1_reg, pin_s2_reg;
  logic [3:0]         low_cnt_reg, low_cnt_next;
  logic               pin_rst_reg, pin_rst_next;
  logic [7:0]         sc2_reg, sc2_next;
  logic [7:0]         wd1_reg, wd1_next;
  clk_state_t         cst_reg, cst_next;
  logic [2:0]         sync_cnt_reg, sync_cnt_next;
  reset_cause_t       cause_reg, cause_next;
  logic               req_reg, req_next;
  logic               rst_out_reg, rst_out_next;
  logic               rst_d_reg;
  logic [1:0]         vec_reg, vec_next;
  logic [7:0]         rdata_next;
  logic               trap_irq_next;
  logic [7:0]         pre_next;
  logic               malf_active;
  logic               trap_hit, clk_fault;
  logic               sc2_wr;
  logic               irq_master_next;
  logic [23:0]        irq_enables_next, irq_latches_next;
  logic               wdt_on_next;

  function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] ofs);
    reg_hit = (a == ofs);
  endfunction : reg_hit

  // pin synchroniser
  always_ff @(posedge clk) begin
    pin_s1_reg <= reset_pin_n;
    pin_s2_reg <= pin_s1_reg;
  end

  // pin low-time qualifier
  // a glitch shorter than the qualifying time only restarts the count
  always_comb begin
    low_cnt_next = 4'h0;
    pin_rst_next = pin_rst_reg;
    if (!pin_s2_reg) begin
      low_cnt_next = low_cnt_reg;
      if (low_cnt_reg != 4'(`EXT_RST_CYCLES)) begin
        low_cnt_next = low_cnt_reg + 4'h1;
      end
      if (low_cnt_next == 4'(`EXT_RST_CYCLES)) begin
        pin_rst_next = 1'b1;
      end
    end else begin
      pin_rst_next = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      low_cnt_reg <= 4'h0;
      pin_rst_reg <= 1'b0;
    end else begin
      low_cnt_reg <= low_cnt_next;
      pin_rst_reg <= pin_rst_next;
    end
  end

  // fault detection
  // a faulting write is dropped, so the oscillator named by the current select bit is never switched off
  assign sc2_wr = wr && reg_hit(addr, `OFS_SYSTEM_CONTROL_TWO);
  always_comb begin
    clk_fault = 1'b0;
    if (sc2_wr && !rst_out_reg) begin
      if (sc2_reg[`BIT_FAST_OSC_ENABLE] && sc2_reg[`BIT_SLOW_OSC_ENABLE] &&
          !wdata[`BIT_FAST_OSC_ENABLE] && !wdata[`BIT_SLOW_OSC_ENABLE]) begin
        clk_fault = 1'b1;
      end
      if (sc2_reg[`BIT_FAST_OSC_ENABLE] && !wdata[`BIT_FAST_OSC_ENABLE] &&
          !sc2_reg[`BIT_CLOCK_SOURCE_SELECT]) begin
        clk_fault = 1'b1;
      end
      if (sc2_reg[`BIT_SLOW_OSC_ENABLE] && !wdata[`BIT_SLOW_OSC_ENABLE] &&
          sc2_reg[`BIT_CLOCK_SOURCE_SELECT]) begin
        clk_fault = 1'b1;
      end
    end
  end

  always_comb begin
    trap_hit = 1'b0;
    if (fetch.valid && !rst_out_reg) begin
      unique case (fetch.area)
        AREA_SPECIAL, AREA_BUFFER: trap_hit = 1'b1;
        AREA_RAM:           trap_hit = wd1_reg[`BIT_RAM_FETCH_TRAP_ENABLE];
        AREA_ROM:           trap_hit = 1'b0;
      endcase
    end
  end

  // combine requests into one registered request
  always_comb begin
    cause_next = cause_reg;
    req_next   = 1'b0;
    if (trap_hit && wd1_reg[`BIT_TRAP_RESET_SELECT]) begin
      cause_next.addr_trap = 1'b1;
      req_next = 1'b1;
    end
    if (watchdog_req) begin
      cause_next.watchdog = 1'b1;
      req_next = 1'b1;
    end
    if (clk_fault) begin
      cause_next.sys_clock = 1'b1;
      req_next = 1'b1;
    end
    if (pin_rst_reg) begin
      cause_next = '0;
      cause_next.ext_pin = 1'b1;
    end
    trap_irq_next = trap_hit && !wd1_reg[`BIT_TRAP_RESET_SELECT];
  end

  // stretch is armed by the block reset, so power-up gives the full stretched reset
  reset_stretch u_stretch (
    .clk        (clk),
    .rst_n      (rst_n),
    .malf_req   (req_reg),
    .malf_active(malf_active)
  );

  // registered internal reset, glitch-free
  assign rst_out_next = !rst_n || pin_rst_reg || malf_active;

  // control registers and clock switch
  always_comb begin
    sc2_next      = sc2_reg;
    wd1_next      = wd1_reg;
    cst_next      = cst_reg;
    sync_cnt_next = sync_cnt_reg;
    if (pin_rst_reg) begin
      sc2_next = `RST_SYSTEM_CONTROL_TWO;
      wd1_next = `RST_WATCHDOG_CONTROL_ONE;
      cst_next = CLK_FAST;
    end else if (rst_out_reg) begin
      // oscillators keep their enables through a malfunction reset
      sc2_next[`BIT_CLOCK_SOURCE_SELECT] = sc2_reg[`BIT_CLOCK_SOURCE_SELECT];
      wd1_next = `RST_WATCHDOG_CONTROL_ONE;
    end else begin
      if (sc2_wr && !clk_fault) begin
        sc2_next = wdata & 8'hE0;
      end
      if (wr && reg_hit(addr, `OFS_WATCHDOG_CONTROL_ONE)) begin
        wd1_next = wdata & 8'h03;
      end
      unique case (cst_reg)
        CLK_FAST: begin
          if (sc2_next[`BIT_CLOCK_SOURCE_SELECT]) cst_next = CLK_SLOW;
        end
        CLK_SLOW: begin
          if (!sc2_next[`BIT_CLOCK_SOURCE_SELECT]) begin
            cst_next      = CLK_SYNC_FAST;
            sync_cnt_next = 3'(`CLK_SYNC_CYCLES);
          end
        end
        CLK_SYNC_FAST: begin
          if (sync_cnt_reg == 3'h0) cst_next = CLK_FAST;
          else sync_cnt_next = sync_cnt_reg - 3'h1;
        end
        default: cst_next = CLK_FAST;
      endcase
    end
  end

  // vector sequence after release
  always_comb begin
    vec_next = vec_reg;
    if (rst_out_reg) begin
      vec_next = 2'h0;
    end else if (rst_d_reg) begin
      vec_next = 2'h1;
    end else if (vec_reg == 2'h1) begin
      vec_next = 2'h2;
    end else if (vec_reg == 2'h2) begin
      vec_next = 2'h0;
    end
  end

  always_comb begin
    rdata_next = 8'h00;
    if (rd) begin
      if (reg_hit(addr, `OFS_SYSTEM_CONTROL_TWO)) rdata_next = sc2_reg;
      else if (reg_hit(addr, `OFS_WATCHDOG_CONTROL_ONE)) rdata_next = wd1_reg;
      else if (reg_hit(addr, `OFS_STATUS))
        rdata_next = {2'b00, cst_reg, cause_reg};
    end
  end

  assign pre_next = rst_out_reg ? 8'h00 : tg_prescaler + 8'h01;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sc2_reg      <= `RST_SYSTEM_CONTROL_TWO;
      wd1_reg      <= `RST_WATCHDOG_CONTROL_ONE;
      cst_reg      <= CLK_FAST;
      sync_cnt_reg <= 3'h0;
      cause_reg    <= '0;
      req_reg      <= 1'b0;
      vec_reg      <= 2'h0;
      rdata        <= 8'h00;
      trap_irq     <= 1'b0;
      tg_prescaler <= 8'h00;
    end else begin
      sc2_reg      <= sc2_next;
      wd1_reg      <= wd1_next;
      cst_reg      <= cst_next;
      sync_cnt_reg <= sync_cnt_next;
      cause_reg    <= cause_next;
      req_reg      <= req_next;
      vec_reg      <= vec_next;
      rdata        <= rdata_next;
      trap_irq     <= trap_irq_next;
      tg_prescaler <= pre_next;
    end
  end

  // interrupt flags are only cleared here; setting them belongs to the interrupt controller
  always_comb begin
    irq_master_next  = master_interrupt_enable;
    irq_enables_next = source_interrupt_enables;
    irq_latches_next = pending_request_latches;
    wdt_on_next      = watchdog_enable;
    if (rst_out_next) begin
      irq_master_next  = 1'b0;
      irq_enables_next = 24'h000000;
      irq_latches_next = 24'h000000;
      wdt_on_next      = 1'b1;
    end
  end

  // outputs, all from flops
  always_ff @(posedge clk) begin
    rst_out_reg              <= rst_out_next;
    rst_d_reg                <= rst_out_reg;
    sys_reset                <= rst_out_next;
    vector_fetch             <= (vec_next != 2'h0);
    vector_addr              <= (vec_next == 2'h2) ? `RESET_VECTOR_HI : `RESET_VECTOR_LO;
    watchdog_enable          <= wdt_on_next;
    fast_osc_enable          <= sc2_next[`BIT_FAST_OSC_ENABLE];
    slow_osc_enable          <= sc2_next[`BIT_SLOW_OSC_ENABLE];
    use_slow_clock           <= (cst_next != CLK_FAST);
    master_interrupt_enable  <= irq_master_next;
    source_interrupt_enables <= irq_enables_next;
    pending_request_latches  <= irq_latches_next;
  end
endmodule : reset_and_clock_switch_ctrl

// ### bench/rst_clk_checker.sv
`timescale 1ns/1ps
module rst_clk_checker
  import rst_clk_pkg::*;
(
  // clock and inputs
  input wire logic                clk,
  input wire logic                rst_n,
  input wire logic                reset_pin_n,
  input rst_clk_pkg::fetch_info_t fetch,
  input wire logic [7:0]          addr,
  input wire logic [7:0]          wdata,
  input wire logic                wr,
  // outputs watched
  input wire logic                sys_reset,
  input wire logic                vector_fetch,
  input wire logic [15:0]         vector_addr,
  input wire logic                trap_irq,
  input wire logic                master_interrupt_enable,
  input wire logic [23:0]         source_interrupt_enables,
  input wire logic [23:0]         pending_request_latches,
  input wire logic [7:0]          tg_prescaler,
  input wire logic                watchdog_enable,
  input wire logic                fast_osc_enable,
  input wire logic                slow_osc_enable,
  input wire logic                use_slow_clock
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // hold count clears while the pin is low so a held pin does not trip the stretch bound; low_cnt times the pin for the pin check
  logic [5:0] hold_cnt;
  logic [4:0] low_cnt;
  always_ff @(posedge clk) begin
    hold_cnt <= (!rst_n || !sys_reset || !reset_pin_n) ? 6'h00 : hold_cnt + 6'h01;
    low_cnt  <= (!rst_n || reset_pin_n) ? 5'h00 : (low_cnt == 5'h1F ? low_cnt : low_cnt + 5'h01);
  end
  a_irq_cleared: assert property (sys_reset ##1 sys_reset |-> !master_interrupt_enable &&
    source_interrupt_enables == 24'h000000 && pending_request_latches == 24'h000000) else $error("flags kept");
  a_tg_cleared: assert property (sys_reset ##1 sys_reset |-> tg_prescaler == 8'h00 && watchdog_enable)
    else $error("prescaler or watchdog wrong");
  a_malf_bound: assert property (hold_cnt <= 6'h1B) else $error("reset too long");
  a_pin_applied: assert property (low_cnt == 5'h12 |-> sys_reset) else $error("pin reset missing");
  a_clk_fault: assert property (wr && addr == 8'h00 && wdata[7:6] == 2'h0 && !sys_reset |-> ##[1:3] sys_reset)
    else $error("no clock reset");
  a_osc_kept: assert property (sys_reset && $past(sys_reset) && reset_pin_n && $past(reset_pin_n) |->
    $stable(fast_osc_enable) && $stable(slow_osc_enable)) else $error("oscillator changed");
  a_vector_seq: assert property ($fell(sys_reset) |-> ##[0:3] (vector_fetch && vector_addr == 16'hFFFE)
    ##1 (vector_fetch && vector_addr == 16'hFFFF)) else $error("vector order");
  a_trap_cause: assert property (trap_irq |-> $past(fetch.valid) && $past(fetch.area) != AREA_ROM)
    else $error("trap without cause");
  a_slow_select: assert property (wr && addr == 8'h00 && wdata[6:5] == 2'h3 && !sys_reset |->
    ##[1:3] use_slow_clock) else $error("slow not taken");
  a_sync_hold: assert property (wr && addr == 8'h00 && wdata[7:5] == 3'h6 && use_slow_clock && !sys_reset |=>
    use_slow_clock[*3] ##[1:4] !use_slow_clock) else $error("switch not synced");
  cover property ($fell(sys_reset));
  cover property (trap_irq);
  cover property ($rose(use_slow_clock));
endmodule : rst_clk_checker

bind reset_and_clock_switch_ctrl rst_clk_checker i_rst_clk_checker (.clk, .rst_n, .reset_pin_n, .fetch, .addr,
  .wdata, .wr, .sys_reset, .vector_fetch, .vector_addr, .trap_irq, .master_interrupt_enable,
  .source_interrupt_enables, .pending_request_latches, .tg_prescaler, .watchdog_enable, .fast_osc_enable,
  .slow_osc_enable, .use_slow_clock);

// ### bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import rst_clk_pkg::*;
  logic        clk, rst_n, reset_pin_n, watchdog_req, wr, rd, sys_reset, vector_fetch, trap_irq;
  logic        master_interrupt_enable, watchdog_enable, fast_osc_enable, slow_osc_enable, use_slow_clock;
  logic [7:0]  addr, wdata, rdata, tg_prescaler;
  logic [15:0] vector_addr;
  logic [23:0] source_interrupt_enables, pending_request_latches;
  fetch_info_t fetch, f;
  int          err_count, n_checks, k;
  logic [31:0] seed;
  logic [7:0]  su[3] = '{8'hC0, 8'hC0, 8'hE0};
  logic [7:0]  fv[3] = '{8'h00, 8'h40, 8'hA0};
  always #4 clk = ~clk;
  reset_and_clock_switch_ctrl i_reset_and_clock_switch_ctrl (.clk, .rst_n, .reset_pin_n, .watchdog_req, .fetch,
    .addr, .wdata, .wr, .rd, .rdata, .sys_reset, .vector_fetch, .vector_addr, .trap_irq, .master_interrupt_enable,
    .source_interrupt_enables, .pending_request_latches, .tg_prescaler, .watchdog_enable, .fast_osc_enable,
    .slow_osc_enable, .use_slow_clock);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic complete_run;
    $display("checks=%0d errors=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction : xs
  function automatic logic trap_exp(input fetch_info_t t, input logic en);
    return t.valid && (t.area == AREA_BUFFER || t.area == AREA_SPECIAL || (t.area == AREA_RAM && en));
  endfunction : trap_exp
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask : rchk
  // k keeps the cycles spent, so callers can bound the stretch
  task automatic wait_rst(input logic lvl, input int lim);
    #1 k = 0;
    while (sys_reset !== lvl && k < lim) begin
      @(posedge clk);
      #1 k++;
    end
    if (k == lim) begin
      err_count++;
      complete_run();
    end
  endtask : wait_rst
  task automatic do_fetch(input fetch_info_t t, input logic en);
    @(posedge clk);
    fetch <= t;
    @(posedge clk);
    fetch <= '0;
    #1 chk(trap_irq, trap_exp(t, en));
  endtask : do_fetch
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    reset_pin_n = 1'b1;
    {watchdog_req, wr, rd, addr, wdata} = '0;
    fetch = '0;
    err_count = 0;
    n_checks = 0;
    seed = 32'h10FB754D;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    wait_rst(1'b0, 40);
    chk(k <= 26, 1'h1);
    chk(watchdog_enable, 1'h1);
    chk(tg_prescaler, 8'h00);
    chk(master_interrupt_enable, 1'h0);
    chk(source_interrupt_enables | pending_request_latches, 32'h0);
    @(posedge clk);
    #1 chk({vector_fetch, vector_addr}, 17'h1FFFE);
    @(posedge clk);
    #1 chk({vector_fetch, vector_addr}, 17'h1FFFF);
    chk(tg_prescaler, 8'h02);
    rchk(8'h00, 8'h80);
    rchk(8'h04, 8'h02);
    rchk(8'h0C, 8'h00);
    wreg(8'h00, 8'hE0);
    repeat (2) @(posedge clk);
    #1 chk(use_slow_clock, 1'h1);
    wreg(8'h00, 8'hC0);
    #1 chk(use_slow_clock, 1'h1);
    repeat (8) @(posedge clk);
    #1 chk(use_slow_clock, 1'h0);
    for (int i = 0; i < 3; i++) begin
      wreg(8'h00, su[i]);
      repeat (8) @(posedge clk);
      wreg(8'h00, fv[i]);
      wait_rst(1'b1, 4);
      chk({fast_osc_enable, slow_osc_enable}, 2'h3);
      wait_rst(1'b0, 40);
      chk(k <= 26, 1'h1);
    end
    @(posedge clk) watchdog_req <= 1'b1;
    @(posedge clk) watchdog_req <= 1'b0;
    wait_rst(1'b1, 4);
    wait_rst(1'b0, 40);
    chk(k <= 26, 1'h1);
    @(posedge clk) fetch <= '{1'b1, AREA_SPECIAL};
    @(posedge clk) fetch <= '0;
    wait_rst(1'b1, 4);
    wait_rst(1'b0, 40);
    rchk(8'h08, 8'h17);
    for (int j = 0; j < 2; j++) begin
      wreg(8'h04, {7'h00, j[0]});
      for (int i = 0; i < 20; i++) begin
        seed = xs(seed);
        f = (i < 8) ? fetch_info_t'(i[2:0]) : fetch_info_t'(seed[2:0]);
        do_fetch(f, j[0]);
      end
    end
    wreg(8'h00, 8'hE0);
    @(posedge clk) reset_pin_n <= 1'b0;
    repeat (5) @(posedge clk);
    reset_pin_n <= 1'b1;
    repeat (6) @(posedge clk);
    #1 chk(sys_reset, 1'h0);
    @(posedge clk) reset_pin_n <= 1'b0;
    repeat (20) @(posedge clk);
    #1 chk(sys_reset, 1'h1);
    @(posedge clk) reset_pin_n <= 1'b1;
    wait_rst(1'b0, 40);
    chk(use_slow_clock, 1'h0);
    rchk(8'h00, 8'h80);
    rchk(8'h08, 8'h08);
    complete_run();
  end
endmodule : tb_top
